// ### tb/cable_model.sv
// Behavioural powered cable seen through the protected pins.
// Assumes level outputs from the switch block and the same clock.
`timescale 1ns/10ps
`default_nettype none
module cable_model (
  input wire logic clk_i, // Clock
  input wire logic [1:0] switch_on_i, // Switch per pin
  input wire logic [1:0] diag_on_i, // Diagnostic current per pin
  input wire logic short_i, // Pin shorted to ground
  input wire logic heavy_i, // Load above high limit
  input wire logic light_i, // Load above low limit
  output logic pin_above_o, // Pin above ground threshold
  output logic ocp_high_o, // High limit comparator
  output logic ocp_low_o // Low limit comparator
);
  initial
  begin
    pin_above_o = 1'b0;
    ocp_high_o = 1'b0;
    ocp_low_o = 1'b0;
  end
  // Undriven pin sits at ground through the cable load
  always @(posedge clk_i)
  begin
    pin_above_o <= |(switch_on_i | diag_on_i) && !short_i;
    ocp_high_o <= |switch_on_i && heavy_i;
    ocp_low_o <= |switch_on_i && light_i;
  end
endmodule : cable_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the cable-power switch control block.
// Assumes shortened timing parameters; retry register set to 1 ms.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  import cable_power_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0;
  axil_req_s req = '0;
  axil_rsp_s rsp;
  logic uv = 1'b0, rev = 1'b0, short_c = 1'b0, heavy = 1'b0, light = 1'b0;
  logic pin_above, ocp_high, ocp_low, lvl, alert_n, stg;
  logic [1:0] sw, diag, disch;
  logic [3:0] ocpl;
  logic [31:0] d;
  logic [1:0] r;
  int err_count = 0, tests_run = 0;

  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end

  cable_power_ctrl #(.US_TICK_CYCLES(2), .STG_WINDOW_US(20), .STG_WAIT_US(30),
    .DISCHARGE_US(10), .SOFT_US(10)) cable_power_ctrl_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .ocp_low_i(ocp_low), .ocp_high_i(ocp_high), .supply_uv_i(uv), .rev_ov_i(rev),
    .pin_above_stg_i(pin_above), .switch_on_o(sw), .diag_on_o(diag), .stg_comp_en_o(stg),
    .discharge_o(disch), .low_overcurrent_select_o(ocpl),
    .supply_undervoltage_level_o(lvl), .alert_n_o(alert_n));

  cable_model cable_model_i (.clk_i(clk_i), .switch_on_i(sw), .diag_on_i(diag),
    .short_i(short_c), .heavy_i(heavy), .light_i(light), .pin_above_o(pin_above),
    .ocp_high_o(ocp_high), .ocp_low_o(ocp_low));

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.awaddr <= {24'h0, a};
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
  endtask : rd

  task automatic wait_sw(input logic [1:0] v, input int n);
    for (int k = 0; k < n && sw !== v; k++) @(posedge clk_i);
  endtask : wait_sw

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #200us;
    err_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(CTRL_OFS);
    `CHK("ctrl", 32'h0, d)
    `CHK("level", 1'b0, lvl)
    rd(RETRY_OFS);
    `CHK("retry", 32'h10, d)
    rd(STATUS_OFS);
    `CHK("status", 32'h0, d)
    rd(8'h0c);
    `CHK("unmapped", RESP_SLVERR, r)
    // Host programs limits, level and pin in the same write that enables
    wr(RETRY_OFS, 32'h1);
    wr(CTRL_OFS, 32'ha7);
    `CHK("ocpl", 4'ha, ocpl)
    `CHK("level", 1'b1, lvl)
    for (int k = 0; k < 10 && diag !== 2'b10; k++) @(posedge clk_i);
    `CHK("diag", 2'b10, diag)
    `CHK("stg comp", 1'b1, stg)
    wait_sw(2'b10, 10);
    `CHK("switch", 2'b10, sw)
    repeat (30) @(posedge clk_i);
    `CHK("diag off", 2'b00, diag)
    rd(STATUS_OFS);
    `CHK("present", 1'b1, d[ST_PRESENT_BIT])
    // High limit: trips after 5 us, three faults raise alert
    heavy <= 1'b1;
    repeat (900) @(posedge clk_i);
    `CHK("ocph early", 2'b10, sw)
    wait_sw(2'b00, 200);
    `CHK("ocph trip", 2'b00, sw)
    `CHK("ocph diag", 2'b10, diag)
    for (int k = 0; k < 8000 && alert_n !== 1'b0; k++) @(posedge clk_i);
    `CHK("alert", 1'b0, alert_n)
    rd(STATUS_OFS);
    `CHK("ocp latch", 1'b1, d[ST_OCP_BIT])
    heavy <= 1'b0;
    repeat (2100) @(posedge clk_i);
    rd(STATUS_OFS);
    `CHK("shield", 1'b1, d[ST_SHIELD_BIT])
    `CHK("ocp count", 2'b00, d[7:6])
    wr(STATUS_OFS, 32'h38);
    rd(STATUS_OFS);
    `CHK("w1c", 3'b000, d[5:3])
    // Disable: discharge on the selected pin for 1 ms scaled
    wr(CTRL_OFS, 32'ha6);
    @(posedge clk_i);
    `CHK("disch", 2'b10, disch)
    `CHK("sw off", 2'b00, sw)
    repeat (15) @(posedge clk_i);
    `CHK("disch hold", 2'b10, disch)
    repeat (10) @(posedge clk_i);
    `CHK("disch end", 2'b00, disch)
    // Detection disabled: overloads ignored
    heavy <= 1'b1;
    light <= 1'b1;
    wr(CTRL_OFS, 32'haf);
    repeat (1200) @(posedge clk_i);
    `CHK("detdis", 2'b10, sw)
    heavy <= 1'b0;
    wr(CTRL_OFS, 32'ha7);
    wait_sw(2'b00, 30);
    `CHK("ocpl trip", 2'b00, sw)
    light <= 1'b0;
    wr(CTRL_OFS, 32'ha6);
    repeat (30) @(posedge clk_i);
    // Short to ground: window, fixed wait, retry, then start
    short_c <= 1'b1;
    wr(CTRL_OFS, 32'ha7);
    repeat (45) @(posedge clk_i);
    `CHK("stg wait", 2'b00, diag)
    `CHK("stg off", 1'b0, stg)
    `CHK("stg sw", 2'b00, sw)
    for (int k = 0; k < 70 && diag !== 2'b10; k++) @(posedge clk_i);
    `CHK("stg retry", 2'b10, diag)
    short_c <= 1'b0;
    wait_sw(2'b10, 10);
    `CHK("stg clear", 2'b10, sw)
    // Undervoltage three times, flag held while present
    for (int i = 0; i < 3; i++)
    begin
      wait_sw(2'b10, 3000);
      uv <= 1'b1;
      wait_sw(2'b00, 4);
      `CHK("uv open", 2'b00, sw)
      if (i < 2) uv <= 1'b0;
    end
    repeat (5) @(posedge clk_i);
    rd(STATUS_OFS);
    `CHK("uv flag", 1'b1, d[ST_UV_BIT])
    uv <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(STATUS_OFS);
    `CHK("uv gone", 1'b0, d[ST_UV_BIT])
    wait_sw(2'b10, 2200);
    `CHK("uv retry", 2'b10, sw)
    // Reverse overvoltage: open at once, flag live, timed restart
    rev <= 1'b1;
    wait_sw(2'b00, 3);
    `CHK("rev open", 2'b00, sw)
    `CHK("rev comp", 1'b1, stg)
    rd(STATUS_OFS);
    `CHK("rev flag", 1'b1, d[ST_REVOV_BIT])
    rev <= 1'b0;
    repeat (1900) @(posedge clk_i);
    `CHK("rev wait", 2'b00, sw)
    wait_sw(2'b10, 300);
    `CHK("rev restart", 2'b10, sw)
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire

// ### verilog/cable_power_ctrl.sv
// Cable-power switch sequencing, fault handling and AXI4-Lite registers.
// Assumes analog comparator inputs synchronous to clk_i and a single clock.
//
// Contract
// - Low overcurrent threshold programmable, fault only after 400 us persistence.
// - Fixed high overcurrent threshold with 5 us debounce.
// - Enabled with valid supply: diag current, then soft-start if pin above ground.
// - Set cable_power_present once soft-start completes.
// - Every start checks short to ground for an 8 ms diagnostic window.
// - Short persists: diag off, wait fixed 16 ms, retry until cleared or disabled.
// - Reverse overvoltage opens switch, diag on, flag held while fault lasts.
// - After reverse overvoltage clears, restart after retry time if still enabled.
// - Overcurrent opens switch and retries; third consecutive fault asserts alert.
// - Autoretry counting applies only to overcurrent and undervoltage faults.
// - Third overcurrent latches fault bit and starts programmed retry timer.
// - Overcurrent retry expiry sets shield flag and restarts the fault counter.
// - Overcurrent latch cleared only by the host over the bus.
// - fault_detect_disable set stops overcurrent fault detection.
// - Undervoltage opens switch, diag on, normal startup once it is gone.
// - Third undervoltage starts retry timer; counter back to zero on expiry.
// - Undervoltage flag set on third fault and held while condition persists.
// - fault_detect_disable hides the undervoltage flag only; alert and actions stay.
// - Undervoltage level selects 4.65 V or 3.05 V, reset 3.05 V.
// - Disabling cable power discharges the selected pin for 1 ms.
`timescale 1ns/10ps
`default_nettype none
module cable_power_ctrl
  import cable_power_pkg::*;
#(
  parameter int unsigned US_TICK_CYCLES = CLK_MHZ,
  parameter int unsigned STG_WINDOW_US = STG_WINDOW_MS * US_PER_MS,
  parameter int unsigned STG_WAIT_US = STG_WAIT_MS * US_PER_MS,
  parameter int unsigned DISCHARGE_US = DISCHARGE_MS * US_PER_MS,
  parameter int unsigned SOFT_US = SOFT_START_US,
  parameter int unsigned OCPL_US = OCPL_DEB_US
) (
  input wire logic clk_i, // 200 MHz clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire axil_req_s axi_req_i, // AXI4-Lite master signals
  output axil_rsp_s axi_rsp_o, // AXI4-Lite slave signals
  input wire logic ocp_low_i, // Load above programmed low limit
  input wire logic ocp_high_i, // Load above fixed high limit
  input wire logic supply_uv_i, // Supply below selected level
  input wire logic rev_ov_i, // Reverse overvoltage on pin
  input wire logic pin_above_stg_i, // Selected pin above ground threshold
  output logic [1:0] switch_on_o, // Cable-power switch per pin
  output logic [1:0] diag_on_o, // Diagnostic current per pin
  output logic stg_comp_en_o, // Ground comparator enable
  output logic [1:0] discharge_o, // Discharge path per pin
  output logic [3:0] low_overcurrent_select_o, // Low limit, 50 mA steps
  output logic supply_undervoltage_level_o, // 1 = 4.65 V, 0 = 3.05 V
  output logic alert_n_o // Alert, active low
);

  typedef struct packed {
    phase_e ph;
    logic [17:0] tmr;
    logic [15:0] us_div;
    logic [8:0] ocpl_cnt;
    logic [9:0] ocph_cnt;
    logic [1:0] ocp_n;
    logic [1:0] uv_n;
    logic cause_ocp;
    logic en;
    logic orient;
    logic uvlvl;
    logic detdis;
    logic [3:0] ocpl_sel;
    logic [7:0] retry_ms;
    logic present;
    logic revov_flag;
    logic uv_flag;
    logic ocp_latch;
    logic shield;
    logic alert;
    logic [1:0] sw;
    logic [1:0] diag;
    logic stg_en;
    logic [1:0] dis;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    axil_rsp_s rsp;
  } state_s;

  localparam state_s STATE_RST = '{
    ph: PH_OFF, ocpl_sel: OCPL_SEL_RST, uvlvl: UVLVL_RST, retry_ms: RETRY_MS_RST,
    rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
    default: '0};

  state_s s_q;
  state_s s_d;

  always_comb
  begin
    logic tick;
    logic [17:0] tmr_next;
    logic active;
    logic ocph_hit;
    logic ocpl_hit;
    logic ocp_trip;
    logic wr_map;
    logic [7:0] wa;
    logic [7:0] ra;
    logic sel;
    phase_e nxt;
    tick = 1'b0;
    tmr_next = '0;
    active = 1'b0;
    ocph_hit = 1'b0;
    ocpl_hit = 1'b0;
    ocp_trip = 1'b0;
    wr_map = 1'b0;
    wa = '0;
    ra = '0;
    sel = 1'b0;
    nxt = s_q.ph;
    s_d = s_q;

    // Write channel: address and data taken in either order
    if (axi_req_i.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req_i.awaddr[7:0];
    end
    if (axi_req_i.wvalid && s_q.rsp.wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req_i.wdata[7:0];
      s_d.wstrb0 = axi_req_i.wstrb[0];
    end
    if (s_q.rsp.bvalid && axi_req_i.bready)
    begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid)
    begin
      wa = s_q.awaddr;
      wr_map = (wa == CTRL_OFS) || (wa == RETRY_OFS) || (wa == STATUS_OFS);
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp = wr_map ? RESP_OKAY : RESP_SLVERR;
      if (s_q.wstrb0 && wa == CTRL_OFS)
      begin
        s_d.en = s_q.wdata[CTRL_EN_BIT];
        s_d.orient = s_q.wdata[CTRL_ORIENT_BIT];
        s_d.uvlvl = s_q.wdata[CTRL_UVLVL_BIT];
        s_d.detdis = s_q.wdata[CTRL_DETDIS_BIT];
        s_d.ocpl_sel = s_q.wdata[CTRL_OCPL_LSB +: 4];
      end
      if (s_q.wstrb0 && wa == RETRY_OFS)
      begin
        s_d.retry_ms = s_q.wdata;
      end
      if (s_q.wstrb0 && wa == STATUS_OFS)
      begin
        // Write one to clear; hardware sets below win
        if (s_q.wdata[ST_OCP_BIT])
        begin
          s_d.ocp_latch = 1'b0;
        end
        if (s_q.wdata[ST_SHIELD_BIT])
        begin
          s_d.shield = 1'b0;
        end
        if (s_q.wdata[ST_ALERT_BIT])
        begin
          s_d.alert = 1'b0;
        end
      end
    end
    s_d.rsp.awready = !s_d.aw_got && !s_d.rsp.bvalid;
    s_d.rsp.wready = !s_d.w_got && !s_d.rsp.bvalid;

    // Read channel
    if (s_q.rsp.rvalid && axi_req_i.rready)
    begin
      s_d.rsp.rvalid = 1'b0;
      s_d.rsp.arready = 1'b1;
    end
    if (axi_req_i.arvalid && s_q.rsp.arready)
    begin
      ra = axi_req_i.araddr[7:0];
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp = RESP_OKAY;
      s_d.rsp.rdata = '0;
      if (axi_req_i.araddr[31:8] != '0)
      begin
        s_d.rsp.rresp = RESP_SLVERR;
      end
      else if (ra == CTRL_OFS)
      begin
        s_d.rsp.rdata[7:0] = {s_q.ocpl_sel, s_q.detdis, s_q.uvlvl, s_q.orient, s_q.en};
      end
      else if (ra == RETRY_OFS)
      begin
        s_d.rsp.rdata[7:0] = s_q.retry_ms;
      end
      else if (ra == STATUS_OFS)
      begin
        s_d.rsp.rdata[ST_PRESENT_BIT] = s_q.present;
        s_d.rsp.rdata[ST_REVOV_BIT] = s_q.revov_flag;
        s_d.rsp.rdata[ST_UV_BIT] = s_q.uv_flag;
        s_d.rsp.rdata[ST_OCP_BIT] = s_q.ocp_latch;
        s_d.rsp.rdata[ST_SHIELD_BIT] = s_q.shield;
        s_d.rsp.rdata[ST_ALERT_BIT] = s_q.alert;
        s_d.rsp.rdata[ST_OCPN_LSB +: 2] = s_q.ocp_n;
        s_d.rsp.rdata[ST_UVN_LSB +: 2] = s_q.uv_n;
      end
      else
      begin
        s_d.rsp.rresp = RESP_SLVERR;
      end
    end

    // Microsecond tick from the clock divider
    tick = (s_q.us_div == 16'(US_TICK_CYCLES - 1));
    s_d.us_div = tick ? '0 : s_q.us_div + 16'h0001;
    tmr_next = tick ? s_q.tmr + 18'h00001 : s_q.tmr;

    // Overcurrent debounce while the switch is closed
    active = (s_q.ph == PH_SOFT) || (s_q.ph == PH_ON);
    // Counters hold at their limit, so a masked overload trips once unmasked
    ocph_hit = active && ocp_high_i && (s_q.ocph_cnt == 10'(OCPH_DEB_CYC - 1));
    s_d.ocph_cnt = (active && ocp_high_i) ? s_q.ocph_cnt + {9'h000, !ocph_hit} : '0;
    ocpl_hit = active && ocp_low_i && tick && (s_q.ocpl_cnt == 9'(OCPL_US - 1));
    s_d.ocpl_cnt = (active && ocp_low_i) ? s_q.ocpl_cnt +
      {8'h00, tick && (s_q.ocpl_cnt != 9'(OCPL_US - 1))} : '0;
    ocp_trip = !s_q.detdis && (ocph_hit || ocpl_hit);

    unique case (s_q.ph)
      PH_OFF:
      begin
        if (s_q.en && !supply_uv_i)
        begin
          nxt = PH_DIAG;
        end
      end
      PH_DISCH:
      begin
        if (tmr_next >= 18'(DISCHARGE_US))
        begin
          nxt = PH_OFF;
        end
      end
      PH_DIAG:
      begin
        if (pin_above_stg_i)
        begin
          nxt = PH_SOFT;
        end
        else if (tmr_next >= 18'(STG_WINDOW_US))
        begin
          nxt = PH_STG_WAIT;
        end
      end
      PH_STG_WAIT:
      begin
        if (tmr_next >= 18'(STG_WAIT_US))
        begin
          nxt = PH_DIAG;
        end
      end
      PH_SOFT, PH_ON:
      begin
        if (rev_ov_i)
        begin
          nxt = PH_REVOV;
        end
        else if (supply_uv_i)
        begin
          if (s_q.uv_n == 2'(FAULTS_TO_RETRY - 1))
          begin
            s_d.uv_n = s_q.uv_n + 2'h1;
            s_d.cause_ocp = 1'b0;
            s_d.alert = 1'b1;
            s_d.uv_flag = !s_q.detdis;
            nxt = PH_RETRY;
          end
          else
          begin
            s_d.uv_n = s_q.uv_n + 2'h1;
            nxt = PH_UV_HOLD;
          end
        end
        else if (ocp_trip)
        begin
          s_d.ocp_n = s_q.ocp_n + 2'h1;
          if (s_q.ocp_n == 2'(FAULTS_TO_RETRY - 1))
          begin
            s_d.ocp_latch = 1'b1;
            s_d.alert = 1'b1;
            s_d.cause_ocp = 1'b1;
            nxt = PH_RETRY;
          end
          else
          begin
            nxt = PH_DIAG;
          end
        end
        else if (s_q.ph == PH_SOFT && tmr_next >= 18'(SOFT_US))
        begin
          nxt = PH_ON;
        end
      end
      PH_UV_HOLD:
      begin
        if (!supply_uv_i)
        begin
          nxt = PH_DIAG;
        end
      end
      PH_REVOV:
      begin
        if (!rev_ov_i)
        begin
          s_d.cause_ocp = 1'b0;
          nxt = PH_RETRY;
        end
      end
      PH_RETRY:
      begin
        if (tmr_next >= 18'(32'(s_q.retry_ms) * US_PER_MS))
        begin
          if (s_q.cause_ocp)
          begin
            s_d.shield = 1'b1;
            s_d.ocp_n = '0;
          end
          else
          begin
            s_d.uv_n = '0;
          end
          nxt = PH_DIAG;
        end
      end
    endcase

    // Disable wins over any sequence
    if (!s_q.en && s_q.ph != PH_OFF && s_q.ph != PH_DISCH)
    begin
      nxt = PH_DISCH;
    end
    if (!s_q.en)
    begin
      s_d.ocp_n = '0;
      s_d.uv_n = '0;
    end

    s_d.ph = nxt;
    s_d.tmr = (nxt != s_q.ph) ? '0 : tmr_next;
    s_d.present = (nxt == PH_ON);
    s_d.revov_flag = (nxt == PH_REVOV);
    if (!supply_uv_i)
    begin
      s_d.uv_flag = 1'b0;
    end

    // Pin drive decode from the next phase
    sel = s_q.orient;
    s_d.sw = '0;
    s_d.diag = '0;
    s_d.dis = '0;
    s_d.sw[sel] = (nxt == PH_SOFT) || (nxt == PH_ON);
    s_d.diag[sel] = (nxt == PH_DIAG) || (nxt == PH_SOFT) || (nxt == PH_UV_HOLD) ||
      (nxt == PH_REVOV);
    s_d.stg_en = s_d.diag[sel];
    s_d.dis[sel] = (nxt == PH_DISCH);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_q <= STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign axi_rsp_o = s_q.rsp;
  assign switch_on_o = s_q.sw;
  assign diag_on_o = s_q.diag;
  assign stg_comp_en_o = s_q.stg_en;
  assign discharge_o = s_q.dis;
  assign low_overcurrent_select_o = s_q.ocpl_sel;
  assign supply_undervoltage_level_o = s_q.uvlvl;
  assign alert_n_o = !s_q.alert;

  property p_disable_opens;
    @(posedge clk_i) disable iff (!rstn_i)
    (!s_q.en && s_q.ph == PH_ON) |=> (switch_on_o == 2'b00) && (discharge_o != 2'b00);
  endproperty
  a_disable_opens: assert property (p_disable_opens) else $error("switch not opened");

  property p_discharge_span;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(discharge_o != 2'b00) |-> (discharge_o != 2'b00) [*8];
  endproperty
  a_discharge_span: assert property (p_discharge_span) else $error("discharge too short");

  property p_present_after_soft;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(s_q.present) |-> $past(s_q.ph) == PH_SOFT;
  endproperty
  a_present_after_soft: assert property (p_present_after_soft) else $error("present early");

  property p_revov_opens;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_q.en && rev_ov_i && s_q.ph == PH_ON) |=> (switch_on_o == 2'b00) && stg_comp_en_o &&
      s_q.revov_flag;
  endproperty
  a_revov_opens: assert property (p_revov_opens) else $error("reverse fault missed");

  property p_uv_flag_follows;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_q.uv_flag && !supply_uv_i) |=> !s_q.uv_flag;
  endproperty
  a_uv_flag_follows: assert property (p_uv_flag_follows) else $error("uv flag stuck");

  property p_shield_from_ocp;
    @(posedge clk_i) disable iff (!rstn_i)
    $rose(s_q.shield) |-> $past(s_q.ph) == PH_RETRY && $past(s_q.cause_ocp) && s_q.ocp_n == 2'h0;
  endproperty
  a_shield_from_ocp: assert property (p_shield_from_ocp) else $error("bad shield set");

  property p_alert_third;
    @(posedge clk_i) disable iff (!rstn_i)
    $fell(alert_n_o) |-> s_q.ph == PH_RETRY && $past(s_q.ocp_n == 2'h2 || s_q.uv_n == 2'h2);
  endproperty
  a_alert_third: assert property (p_alert_third) else $error("alert not on third fault");

  property p_diag_window;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_q.ph == PH_DIAG) |-> diag_on_o != 2'b00 && stg_comp_en_o && switch_on_o == 2'b00;
  endproperty
  a_diag_window: assert property (p_diag_window) else $error("diag state drive wrong");

  property p_stg_wait_quiet;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_q.ph == PH_STG_WAIT) |-> diag_on_o == 2'b00 && switch_on_o == 2'b00;
  endproperty
  a_stg_wait_quiet: assert property (p_stg_wait_quiet) else $error("diag on during wait");

  property p_detdis_no_ocp;
    @(posedge clk_i) disable iff (!rstn_i)
    (s_q.detdis && s_q.ph == PH_ON && !supply_uv_i && !rev_ov_i && s_q.en) |=>
      s_q.ph == PH_ON && $stable(s_q.ocp_n);
  endproperty
  a_detdis_no_ocp: assert property (p_detdis_no_ocp) else $error("ocp seen while off");

endmodule : cable_power_ctrl
`default_nettype wire

// ### verilog/cable_power_pkg.sv
// Package for the cable-power switch control block.
// Assumes a 200 MHz clock and an AXI4-Lite register master.
package cable_power_pkg;

  // Clock and time base
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned OCPH_DEB_NS = 5000;
  localparam int unsigned OCPH_DEB_CYC = (OCPH_DEB_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OCPL_DEB_US = 400;
  localparam int unsigned SOFT_START_US = 500;
  localparam int unsigned STG_WINDOW_MS = 8;
  localparam int unsigned STG_WAIT_MS = 16;
  localparam int unsigned DISCHARGE_MS = 1;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned FAULTS_TO_RETRY = 3;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RETRY_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_ORIENT_BIT = 1;
  localparam int unsigned CTRL_UVLVL_BIT = 2;
  localparam int unsigned CTRL_DETDIS_BIT = 3;
  localparam int unsigned CTRL_OCPL_LSB = 4;

  // Status register fields
  localparam int unsigned ST_PRESENT_BIT = 0;
  localparam int unsigned ST_REVOV_BIT = 1;
  localparam int unsigned ST_UV_BIT = 2;
  localparam int unsigned ST_OCP_BIT = 3;
  localparam int unsigned ST_SHIELD_BIT = 4;
  localparam int unsigned ST_ALERT_BIT = 5;
  localparam int unsigned ST_OCPN_LSB = 6;
  localparam int unsigned ST_UVN_LSB = 8;

  // Reset values
  localparam logic [3:0] OCPL_SEL_RST = 4'h0;
  localparam logic UVLVL_RST = 1'b0;
  localparam logic [7:0] RETRY_MS_RST = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PH_OFF, PH_DISCH, PH_DIAG, PH_STG_WAIT, PH_SOFT, PH_ON, PH_UV_HOLD, PH_REVOV, PH_RETRY
  } phase_e;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

endpackage : cable_power_pkg
